/* dv/output_control_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module output_control_assertions (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        bus_init,
  input wire logic        out1_o,
  input wire logic        out1_oe,
  input wire logic        out2_o,
  input wire logic        out2_oe,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire rd_setup = psel && !penable && !pwrite && ce;
  wire unmapped = paddr[7:2] > 6'h11;
  wire access   = psel && penable;
  // ****************************************************************
  // bus answer
  // ****************************************************************
  chk_ready_ce: assert property (pready == ce)
    else $error("pready does not follow ce");
  chk_unmapped_err: assert property (access && unmapped |-> pslverr)
    else $error("unmapped access without error");
  chk_mapped_ok: assert property (access && !unmapped |-> !pslverr)
    else $error("mapped access flagged as error");
  chk_unmapped_zero: assert property (access && !pwrite && unmapped
    && $past(rd_setup) |-> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  chk_rdata_hold: assert property (!rd_setup |=> $stable(prdata))
    else $error("read data changed outside a read setup");
  // ****************************************************************
  // pin drive
  // ****************************************************************
  chk_out1_release: assert property (!out1_oe |-> !out1_o)
    else $error("output 1 level driven while released");
  chk_out2_release: assert property (!out2_oe |-> !out2_o)
    else $error("output 2 level driven while released");
  chk_freeze_ce: assert property (!ce |=>
    $stable({out1_o, out1_oe, out2_o, out2_oe, irq}))
    else $error("state moved while clock enable low");
  cov_irq: cover property ($rose(irq));
  cov_slverr: cover property (access && pslverr);
  cov_init: cover property (bus_init);
  cov_out1: cover property ($rose(out1_oe));
endmodule // output_control_assertions
bind output_control output_control_assertions chk_i (
  .mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .bus_init(bus_init), .out1_o(out1_o),
  .out1_oe(out1_oe), .out2_o(out2_o), .out2_oe(out2_oe), .irq(irq));
`default_nettype wire

/* dv/serial_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "indicator_map.vh"
module serial_master_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       init_req,
  input  wire logic [1:0] kind1,
  input  wire logic [1:0] kind2,
  input  wire logic       out1_o,
  input  wire logic       out1_oe,
  input  wire logic       out2_o,
  input  wire logic       out2_oe,
  output var  logic       bus_init,
  output wire logic       line1,
  output wire logic       line2
);
  logic req_d;
  // ****************************************************************
  // bus initialisation, one pulse per request
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_d <= 1'b0;
      bus_init <= 1'b0;
    end else begin
      req_d <= init_req;
      bus_init <= init_req & ~req_d;
    end
  end
  // ****************************************************************
  // loads
  // ****************************************************************
  // pull-up behind a low-side switch, pull-down behind the others
  assign line1 = out1_oe ? out1_o : (kind1 == `KIND_LOW);
  assign line2 = out2_oe ? out2_o : (kind2 == `KIND_LOW);
endmodule // serial_master_model
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "indicator_map.vh"
module testbench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] meas_value = 16'h0000;
  logic        meas_error = 1'b0;
  logic        init_req = 1'b0;
  logic [1:0]  kind1 = `KIND_LOW;
  logic        last_err;
  logic [31:0] rd;
  wire         pready, pslverr, irq, bus_init, line1, line2;
  wire         out1_o, out1_oe, out2_o, out2_oe;
  wire  [31:0] prdata;
  wire  [3:0]  pins = {out1_oe, out1_o, out2_oe, out2_o};
  int          err_count = 0;
  int          n_checks = 0;
  int          n;
  output_control #(.STEP_CYCLES(32'd4), .SEC_STEPS(14'd3),
    .EDIT_STEPS(14'd5)) output_control_i (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .meas_value(meas_value),
    .meas_error(meas_error), .bus_init(bus_init), .out1_o(out1_o),
    .out1_oe(out1_oe), .out2_o(out2_o), .out2_oe(out2_oe), .irq(irq));
  serial_master_model serial_master_model_i (
    .mclk(mclk), .rst_n(rst_n), .init_req(init_req), .kind1(kind1),
    .kind2(`KIND_LOW), .out1_o(out1_o), .out1_oe(out1_oe),
    .out2_o(out2_o), .out2_oe(out2_oe), .bus_init(bus_init),
    .line1(line1), .line2(line2));
  initial forever #50 mclk = ~mclk;
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input string what, input [31:0] exp, input [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // held from setup until pready is seen high at an edge, released at that same edge
  task automatic apb(input w, input [7:0] a, input [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 50) begin
        err_count++;
        end_sim;
      end
      @(posedge mclk);
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string what, input [7:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(what, exp, rd);
  endtask
  task automatic look_irq(input exp);
    @(negedge mclk);
    cmp("irq", {31'h0, exp}, {31'h0, irq});
    @(posedge mclk);
  endtask
  task automatic wait_pins(input [3:0] exp, input int lim);
    n = 0;
    @(negedge mclk);
    while (pins !== exp && n < lim) begin
      n++;
      @(negedge mclk);
    end
    cmp("pins", {28'h0, exp}, {28'h0, pins});
    if (pins !== exp) end_sim;
    @(posedge mclk);
  endtask
  function automatic [1:0] pin_exp(input [1:0] k, input a);
    case (k)
      `KIND_LOW:  pin_exp = {a, 1'b0};
      `KIND_HIGH: pin_exp = {a, a};
      default:    pin_exp = {1'b1, a};
    endcase
  endfunction
  task automatic t_reset;
    rchk("ctrl", `OFS_CTRL, 32'h0000_0000);
    rchk("out1", `OFS_OUT1, 32'h0000_0001);
    rchk("unmapped", 8'h48, 32'h0000_0000);
    cmp("slverr", 32'h1, {31'h0, last_err});
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
  endtask
  task automatic t_addr;
    wr(`OFS_ADDR, 32'h0000_00EF);
    rchk("addr max", `OFS_ADDR, 32'h0000_00EF);
    wr(`OFS_ADDR, 32'h0000_00F0);
    rchk("addr clamp", `OFS_ADDR, 32'h0000_00EF);
    wr(`OFS_INT_EN, 32'h0000_0010);
    init_req <= 1'b1;
    @(posedge mclk);
    init_req <= 1'b0;
    repeat (3) @(posedge mclk);
    rchk("addr init", `OFS_ADDR, 32'h0000_0000);
    rchk("int sts", `OFS_INT_STS, 32'h0000_0010);
    look_irq(1'b1);
    wr(`OFS_INT_EN, 32'h0000_0000);
    look_irq(1'b0);
    wr(`OFS_INT_EN, 32'h0000_0010);
    wr(`OFS_INT_CLR, 32'h0000_0010);
    look_irq(1'b0);
  endtask
  task automatic t_serial;
    meas_value <= 16'h01F4;
    meas_error <= 1'b1;
    wr(`OFS_CTRL, 32'h0000_0003);
    wr(`OFS_OUT1, 32'h0000_0203);
    wr(`OFS_SERVAL, 32'h0000_006E);
    wr(`OFS_THR0, 32'h0000_0064);
    wr(`OFS_THR0 + 8'h04, 32'h0000_0066);
    wr(`OFS_EDIT, 32'h0000_0001);
    wait_pins(4'b1000, 20);
    wr(`OFS_SERVAL, 32'h0000_005A);
    wait_pins(4'b1100, 20);
    cmp("delay", 32'h1, {31'h0, n >= 5});
    wr(`OFS_SERVAL, 32'h0000_0065);
    repeat (20) @(posedge mclk);
    wait_pins(4'b1100, 0);
    wr(`OFS_SERVAL, 32'h0000_0067);
    wait_pins(4'b1000, 20);
    rchk("disp", `OFS_DISP, 32'h0000_0067);
    meas_error <= 1'b0;
  endtask
  task automatic t_error;
    wr(`OFS_CTRL, 32'h0000_0012);
    for (int k = 0; k < 3; k++) begin
      for (int e = 0; e < 2; e++) begin
        kind1 <= k[1:0];
        wr(`OFS_OUT1, 32'h0000_0001 | (k << 8) | (e << 10));
        wait_pins({pin_exp(k[1:0], e[0]), 2'b00}, 20);
        cmp("line1", {31'h0, e[0] ^ (k == 0)}, {31'h0, line1});
      end
    end
  endtask
  task automatic t_alarm;
    wr(`OFS_CTRL, 32'h0000_000B);
    wr(`OFS_ALCFG, 32'h0002_0002);
    wr(`OFS_SERVAL, 32'h0000_0064);
    wr(`OFS_THR0 + 8'h10, 32'h0000_00C8);
    wr(`OFS_THR0 + 8'h14, 32'h0000_0032);
    wr(`OFS_EDIT, 32'h0000_0001);
    wait_pins(4'b1111, 40);
    wr(`OFS_INT_CLR, 32'h0000_001F);
    wr(`OFS_SERVAL, 32'h0000_012C);
    wait_pins(4'b1011, 40);
    cmp("alarm delay", 32'h1, {31'h0, n >= 12});
    apb(1'b0, `OFS_INT_STS, 32'h0000_0000);
    cmp("alarm event", 32'h1, {31'h0, rd[`EV_ALARM]});
    wr(`OFS_ALCFG, 32'h0001_0000);
    wait_pins(4'b0010, 20);
    cmp("line2", 32'h0, {31'h0, line2});
  endtask
  task automatic t_unused;
    wr(`OFS_CTRL, 32'h0000_0002);
    wr(`OFS_OUT2, 32'h0000_0205);
    rchk("out2 dropped", `OFS_OUT2, 32'h0000_0001);
    wr(`OFS_ALCFG, 32'h0000_0002);
    rchk("alcfg dropped", `OFS_ALCFG, 32'h0001_0000);
    wr(`OFS_CTRL, 32'h0000_0004);
    wr(`OFS_OUT2, 32'h0000_0205);
    rchk("out2 kept", `OFS_OUT2, 32'h0000_0205);
  endtask
  task automatic t_edit;
    wr(`OFS_THR0, 32'h0000_0007);
    rchk("edit open", `OFS_EDIT, 32'h0000_0001);
    repeat (28) @(posedge mclk);
    rchk("edit dropped", `OFS_EDIT, 32'h0000_0000);
    apb(1'b0, `OFS_INT_STS, 32'h0000_0000);
    cmp("edit event", 32'h1, {31'h0, rd[`EV_EDIT_TO]});
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_addr;
    t_serial;
    t_error;
    t_alarm;
    t_unused;
    t_edit;
    end_sim;
  end
  initial begin
    #3000000;
    err_count++;
    end_sim;
  end
endmodule // testbench
`default_nettype wire

/* hdl/indicator_map.vh */
`ifndef INDICATOR_MAP_VH
`define INDICATOR_MAP_VH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL      8'h00
`define OFS_ADDR      8'h04
`define OFS_OUT1      8'h08
`define OFS_OUT2      8'h0C
`define OFS_ALCFG     8'h10
`define OFS_THR0      8'h14
`define OFS_THR5      8'h28
`define OFS_SERVAL    8'h2C
`define OFS_STATUS    8'h30
`define OFS_DISP      8'h34
`define OFS_INT_STS   8'h38
`define OFS_INT_CLR   8'h3C
`define OFS_INT_EN    8'h40
`define OFS_EDIT      8'h44
// ****************************************************************
// threshold slots
// ****************************************************************
`define THR_1ON       3'd0
`define THR_1OFF      3'd1
`define THR_2ON       3'd2
`define THR_2OFF      3'd3
`define THR_ALHI      3'd4
`define THR_ALLO      3'd5
// ****************************************************************
// fields
// ****************************************************************
`define CTRL_SERIAL   0
`define CTRL_FN_LO    1
`define CTRL_FN_HI    3
`define CTRL_FORCE    4
`define OUT_KIND_LO   8
`define OUT_KIND_HI   9
`define OUT_ERR       10
`define AL_DEL_LO     16
`define AL_DEL_HI     29
`define EDIT_COMMIT   0
`define EDIT_CANCEL   1
// ****************************************************************
// encodings
// ****************************************************************
`define FN_NONE       3'd0
`define FN_TWO        3'd1
`define FN_THREE      3'd2
`define FN_CTL_AL     3'd3
`define FN_AL_COMMON  3'd4
`define FN_AL_INDIV   3'd5
`define KIND_LOW      2'd0
`define KIND_HIGH     2'd1
`define KIND_PP       2'd2
`define EV_OUT1       0
`define EV_OUT2       1
`define EV_ALARM      2
`define EV_EDIT_TO    3
`define EV_BUS_INIT   4
`define EV_W          5
// ****************************************************************
// reset values and limits
// ****************************************************************
`define ADDR_MAX      8'hEF
`define ADDR_RESET    8'h00
`define DEL_MIN       8'h01
`define DEL_MAX       8'hC8
`define DEL_RESET     8'h01
// ****************************************************************
// timing
// ****************************************************************
`define CLK_KHZ       10000
`define T_STEP_MS     10
`define STEP_CYCLES   (`T_STEP_MS * `CLK_KHZ)
`define T_SEC_MS      1000
`define SEC_STEPS     (`T_SEC_MS / `T_STEP_MS)
`define T_EDIT_S      60
`define EDIT_STEPS    (`T_EDIT_S * `SEC_STEPS)
`endif

/* hdl/output_control.v */
// Summary of operation
// [RL1] serial mode ignores the measured input; display comes from serial value
// [RL2] switching and alarms keep working on the displayed value
// [RL3] bus address is held within 0 to 239
// [RL4] master bus initialisation resets the stored bus address
// [RL5] six output functions select what drives outputs 1 and 2
// [RL6] settings for outputs unused by the function are not accepted; the output 1 error state is taken under every function
// [RL7] controller outputs delay 0.01 s to 2.00 s in 0.01 s steps
// [RL8] drive kind per controller output: low side, high side, push-pull
// [RL9] on error each output takes its configured preferred state
// [RL10] three-level mode gives output 2 its own delay, kind, error state
// [RL11] alarm outputs are active without alarm, inactive with alarm
// [RL12] push-pull alarm high without alarm; switches closed without alarm
// [RL13] individual alarm mode uses one shared alarm drive kind
// [RL14] thresholds stay adjustable separately from output configuration
// [RL15] controller turns on at its on point, off at its off point; the code switches only once the value lies strictly beyond the point
// [RL16] alarm raised only after its condition persists for the alarm delay
// [RL17] threshold editing idle over 60 s is dropped unsaved
// [RL18] output follows only after the new condition persisted for the delay
`timescale 1ns/1ps
`default_nettype none
`include "indicator_map.vh"
module output_control #(
  parameter [31:0] STEP_CYCLES = `STEP_CYCLES,
  parameter [13:0] SEC_STEPS   = `SEC_STEPS,
  parameter [13:0] EDIT_STEPS  = `EDIT_STEPS
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [15:0] meas_value,
  input  wire        meas_error,
  input  wire        bus_init,
  output reg         out1_o,
  output reg         out1_oe,
  output reg         out2_o,
  output reg         out2_oe,
  output wire        irq
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function [7:0] clamp_del;
    input [7:0] d;
    begin
      if (d < `DEL_MIN) clamp_del = `DEL_MIN;
      else if (d > `DEL_MAX) clamp_del = `DEL_MAX;
      else clamp_del = d;
    end
  endfunction
  function [1:0] clamp_kind;
    input [1:0] k;
    begin
      clamp_kind = (k > `KIND_PP) ? `KIND_PP : k;
    end
  endfunction
  // heating when on point at or below off point, cooling otherwise
  function ctl_next;
    input        cur;
    input [15:0] v;
    input [15:0] on_pt;
    input [15:0] off_pt;
    begin
      ctl_next = cur;
      if ($signed(on_pt) <= $signed(off_pt)) begin
        if ($signed(v) < $signed(on_pt)) ctl_next = 1'b1; // RL15
        else if ($signed(v) > $signed(off_pt)) ctl_next = 1'b0; // RL15
      end else begin
        if ($signed(v) > $signed(on_pt)) ctl_next = 1'b1; // RL15
        else if ($signed(v) < $signed(off_pt)) ctl_next = 1'b0; // RL15
      end
    end
  endfunction
  // returns {oe, o}; a switch that is open is not driven
  function [1:0] pin_drive;
    input [1:0] kind;
    input       act;
    begin
      case (kind)
        `KIND_LOW:  pin_drive = {act, 1'b0}; // RL8
        `KIND_HIGH: pin_drive = {act, act}; // RL8
        `KIND_PP:   pin_drive = {1'b1, act}; // RL8
        default:    pin_drive = 2'b00;
      endcase
    end
  endfunction
  // ****************************************************************
  // registers
  // ****************************************************************
  reg        serial_reg;
  reg [2:0]  fn_reg;
  reg        force_err_reg;
  reg [7:0]  addr_reg;
  reg [7:0]  del1_reg;
  reg [1:0]  kind1_reg;
  reg        err1_reg;
  reg [7:0]  del2_reg;
  reg [1:0]  kind2_reg;
  reg        err2_reg;
  reg [1:0]  al_kind_reg;
  reg [13:0] al_del_reg;
  reg [15:0] serval_reg;
  reg [15:0] thr_live [0:5];
  reg [15:0] thr_edit [0:5];
  reg        edit_reg;
  reg [13:0] idle_reg;
  reg [`EV_W-1:0] int_sts_reg;
  reg [`EV_W-1:0] int_en_reg;
  reg [31:0] step_cnt_reg;
  reg [13:0] sec_cnt_reg;
  reg        ctl1_reg;
  reg        ctl2_reg;
  reg        alarm_any_reg;
  integer    i;
  wire [7:0] a = {paddr[7:2], 2'b00};
  wire wr_en  = psel & penable & pwrite & ce;
  wire rd_set = psel & ~penable & ~pwrite & ce;
  wire thr_hit = (a >= `OFS_THR0) && (a <= `OFS_THR5);
  wire [2:0] thr_idx = a[4:2] - 3'd5;
  wire mapped = (a <= `OFS_EDIT);
  wire fn_uses2 = (fn_reg == `FN_THREE); // RL10
  wire fn_alarm = (fn_reg >= `FN_CTL_AL) && (fn_reg <= `FN_AL_INDIV);
  assign pready  = ce;
  assign pslverr = psel & penable & ~mapped;
  // ****************************************************************
  // time base
  // ****************************************************************
  wire step_tick = (step_cnt_reg == STEP_CYCLES - 32'd1);
  wire sec_tick  = step_tick && (sec_cnt_reg == SEC_STEPS - 14'd1);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_reg <= 32'h0000_0000;
      sec_cnt_reg  <= 14'h0000;
    end else if (ce) begin
      step_cnt_reg <= step_tick ? 32'h0000_0000 : step_cnt_reg + 32'd1;
      if (sec_tick) sec_cnt_reg <= 14'h0000;
      else if (step_tick) sec_cnt_reg <= sec_cnt_reg + 14'd1;
    end
  end
  // ****************************************************************
  // value path and evaluation
  // ****************************************************************
  wire [15:0] disp_value = serial_reg ? serval_reg : meas_value; // RL1
  wire        err_now = force_err_reg | (meas_error & ~serial_reg);
  wire        max_cond = $signed(disp_value) > $signed(thr_live[4]); // RL2
  wire        min_cond = $signed(disp_value) < $signed(thr_live[5]); // RL2
  wire        want1 = ctl_next(ctl1_reg, disp_value, thr_live[0],
                               thr_live[1]);
  wire        want2 = ctl_next(ctl2_reg, disp_value, thr_live[2],
                               thr_live[3]);
  wire        max_al;
  wire        min_al;
  wire        d1;
  wire        d2;
  persist_filter u_del1 (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .tick(step_tick),
    .cond(ctl1_reg), .delay({6'h00, del1_reg}), .state(d1)); // RL7 RL18
  persist_filter u_del2 (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .tick(step_tick),
    .cond(ctl2_reg), .delay({6'h00, del2_reg}), .state(d2)); // RL7 RL10
  persist_filter u_amax (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .tick(sec_tick),
    .cond(max_cond), .delay(al_del_reg), .state(max_al)); // RL16
  persist_filter u_amin (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .tick(sec_tick),
    .cond(min_cond), .delay(al_del_reg), .state(min_al)); // RL16
  // ****************************************************************
  // output function mapping
  // ****************************************************************
  reg       act1;
  reg       act2;
  reg [1:0] k1;
  reg [1:0] k2;
  always @* begin
    act1 = 1'b0;
    act2 = 1'b0;
    k1 = kind1_reg;
    k2 = kind2_reg;
    case (fn_reg)
      `FN_TWO: begin
        act1 = d1; // RL5
      end
      `FN_THREE: begin
        act1 = d1; // RL5
        act2 = d2; // RL10
      end
      `FN_CTL_AL: begin
        act1 = d1;
        act2 = ~(max_al | min_al); // RL11
        k2 = al_kind_reg; // RL12
      end
      `FN_AL_COMMON: begin
        act2 = ~(max_al | min_al); // RL11
        k2 = al_kind_reg; // RL12
      end
      `FN_AL_INDIV: begin
        act1 = ~max_al; // RL11
        act2 = ~min_al; // RL11
        k1 = al_kind_reg; // RL13
        k2 = al_kind_reg; // RL13
      end
      default: begin
        act1 = 1'b0;
      end
    endcase
    if (err_now) begin
      act1 = err1_reg; // RL9
      act2 = err2_reg; // RL9
    end
  end
  wire [1:0] pd1 = pin_drive(k1, act1);
  wire [1:0] pd2 = pin_drive(k2, act2);
  wire       alarm_any = fn_alarm & (max_al | min_al);
  // ****************************************************************
  // interrupt events
  // ****************************************************************
  reg out1_act_q;
  reg out2_act_q;
  reg [`EV_W-1:0] ev;
  wire idle_to = edit_reg && (idle_reg >= EDIT_STEPS);
  always @* begin
    ev = {`EV_W{1'b0}};
    ev[`EV_OUT1]    = (act1 != out1_act_q);
    ev[`EV_OUT2]    = (act2 != out2_act_q);
    ev[`EV_ALARM]   = alarm_any & ~alarm_any_reg;
    ev[`EV_EDIT_TO] = idle_to;
    ev[`EV_BUS_INIT] = bus_init;
  end
  assign irq = |(int_sts_reg & int_en_reg);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out1_o <= 1'b0;
      out1_oe <= 1'b0;
      out2_o <= 1'b0;
      out2_oe <= 1'b0;
      out1_act_q <= 1'b0;
      out2_act_q <= 1'b0;
      ctl1_reg <= 1'b0;
      ctl2_reg <= 1'b0;
      alarm_any_reg <= 1'b0;
    end else if (ce) begin
      {out1_oe, out1_o} <= pd1;
      {out2_oe, out2_o} <= pd2;
      out1_act_q <= act1;
      out2_act_q <= act2;
      ctl1_reg <= want1;
      ctl2_reg <= want2;
      alarm_any_reg <= alarm_any;
    end
  end
  // ****************************************************************
  // register writes
  // ****************************************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial_reg <= 1'b0;
      fn_reg <= `FN_NONE;
      force_err_reg <= 1'b0;
      addr_reg <= `ADDR_RESET;
      del1_reg <= `DEL_RESET;
      kind1_reg <= `KIND_LOW;
      err1_reg <= 1'b0;
      del2_reg <= `DEL_RESET;
      kind2_reg <= `KIND_LOW;
      err2_reg <= 1'b0;
      al_kind_reg <= `KIND_LOW;
      al_del_reg <= 14'h0000;
      serval_reg <= 16'h0000;
      edit_reg <= 1'b0;
      idle_reg <= 14'h0000;
      int_sts_reg <= {`EV_W{1'b0}};
      int_en_reg <= {`EV_W{1'b0}};
      for (i = 0; i < 6; i = i + 1) begin
        thr_live[i] <= 16'h0000;
        thr_edit[i] <= 16'h0000;
      end
    end else if (ce) begin
      // a set in the same cycle as its clear is kept
      int_sts_reg <= (int_sts_reg &
        ~((wr_en && a == `OFS_INT_CLR) ? pwdata[`EV_W-1:0] :
          {`EV_W{1'b0}})) | ev;
      if (edit_reg && step_tick) idle_reg <= idle_reg + 14'd1;
      if (idle_to) begin
        edit_reg <= 1'b0; // RL17
        idle_reg <= 14'h0000;
      end
      if (wr_en) begin
        case (a)
          `OFS_CTRL: begin
            serial_reg <= pwdata[`CTRL_SERIAL];
            fn_reg <= (pwdata[`CTRL_FN_HI:`CTRL_FN_LO] > `FN_AL_INDIV) ?
                      fn_reg : pwdata[`CTRL_FN_HI:`CTRL_FN_LO]; // RL5
            force_err_reg <= pwdata[`CTRL_FORCE];
          end
          `OFS_ADDR: begin
            addr_reg <= (pwdata[7:0] > `ADDR_MAX) ? `ADDR_MAX :
                        pwdata[7:0]; // RL3
          end
          `OFS_OUT1: begin
            if (fn_reg != `FN_NONE && fn_reg != `FN_AL_COMMON &&
                fn_reg != `FN_AL_INDIV) begin // RL6
              del1_reg <= clamp_del(pwdata[7:0]); // RL7
              kind1_reg <= clamp_kind(
                pwdata[`OUT_KIND_HI:`OUT_KIND_LO]);
            end
            err1_reg <= pwdata[`OUT_ERR];
          end
          `OFS_OUT2: begin
            if (fn_uses2) begin // RL6 RL10
              del2_reg <= clamp_del(pwdata[7:0]);
              kind2_reg <= clamp_kind(
                pwdata[`OUT_KIND_HI:`OUT_KIND_LO]);
            end
            if (fn_reg != `FN_NONE && fn_reg != `FN_TWO) begin
              err2_reg <= pwdata[`OUT_ERR];
            end
          end
          `OFS_ALCFG: begin
            if (fn_alarm) begin // RL6
              al_kind_reg <= clamp_kind(pwdata[1:0]);
              al_del_reg <= (pwdata[`AL_DEL_HI:`AL_DEL_LO] > 14'd9999) ?
                            14'd9999 : pwdata[`AL_DEL_HI:`AL_DEL_LO];
            end
          end
          `OFS_SERVAL: begin
            serval_reg <= pwdata[15:0];
          end
          `OFS_INT_EN: begin
            int_en_reg <= pwdata[`EV_W-1:0];
          end
          `OFS_EDIT: begin
            edit_reg <= 1'b0;
            idle_reg <= 14'h0000;
            for (i = 0; i < 6; i = i + 1) begin
              if (pwdata[`EDIT_COMMIT] && edit_reg && !idle_to)
                thr_live[i] <= thr_edit[i]; // RL14
            end
          end
          default: begin
            if (thr_hit) begin
              if (!edit_reg || idle_to) begin
                for (i = 0; i < 6; i = i + 1)
                  thr_edit[i] <= thr_live[i];
              end
              thr_edit[thr_idx] <= pwdata[15:0]; // RL14
              edit_reg <= 1'b1;
              idle_reg <= 14'h0000;
            end
          end
        endcase
      end
      if (bus_init) addr_reg <= `ADDR_RESET; // RL4
    end
  end
  // ****************************************************************
  // register reads
  // ****************************************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_set) begin
      case (a)
        `OFS_CTRL:    prdata <= {27'h000_0000, force_err_reg, fn_reg,
                                 serial_reg};
        `OFS_ADDR:    prdata <= {24'h00_0000, addr_reg};
        `OFS_OUT1:    prdata <= {21'h00_0000, err1_reg, kind1_reg,
                                 del1_reg};
        `OFS_OUT2:    prdata <= {21'h00_0000, err2_reg, kind2_reg,
                                 del2_reg};
        `OFS_ALCFG:   prdata <= {2'b00, al_del_reg, 14'h0000,
                                 al_kind_reg};
        `OFS_SERVAL:  prdata <= {16'h0000, serval_reg};
        `OFS_STATUS:  prdata <= {24'h00_0000, 1'b0, edit_reg, err_now,
                                 min_al, max_al, d2, out2_act_q,
                                 out1_act_q};
        `OFS_DISP:    prdata <= {16'h0000, disp_value};
        `OFS_INT_STS: prdata <= {27'h000_0000, int_sts_reg};
        `OFS_INT_EN:  prdata <= {27'h000_0000, int_en_reg};
        `OFS_EDIT:    prdata <= {31'h0000_0000, edit_reg};
        default: begin
          if (thr_hit)
            prdata <= {16'h0000, edit_reg ? thr_edit[thr_idx] :
                                            thr_live[thr_idx]};
          else
            prdata <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule // output_control
`default_nettype wire

/* hdl/persist_filter.v */
`timescale 1ns/1ps
`default_nettype none
module persist_filter (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        tick,
  input  wire        cond,
  input  wire [13:0] delay,
  output wire        state
);
  reg        state_reg;
  reg [13:0] cnt_reg;
  assign state = state_reg;
  // the new condition must hold without a break for the delay
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= 1'b0;
      cnt_reg   <= 14'h0000;
    end else if (ce) begin
      if (cond == state_reg) begin
        cnt_reg <= 14'h0000;
      end else if (delay == 14'h0000) begin
        state_reg <= cond;
      end else if (tick) begin
        if (cnt_reg + 14'h0001 >= delay) begin
          state_reg <= cond;
          cnt_reg   <= 14'h0000;
        end else begin
          cnt_reg <= cnt_reg + 14'h0001;
        end
      end
    end
  end
endmodule // persist_filter
`default_nettype wire
